// ===== dhc_pkg.sv
// Shared constants for the display host command decoder: opcodes, field
// positions, reset values and the register map of the Wishbone slave.
// Assumes a single 100 MHz system clock shared by decoder and bus.
package dhc_pkg;

  // ==========================================================================
  // Command opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SOFT_RESET = 8'h01;
  localparam logic [7:0] OP_GET_POWER = 8'h0a;
  localparam logic [7:0] OP_GET_ADDR = 8'h0b;
  localparam logic [7:0] OP_GET_PIXFMT = 8'h0c;
  localparam logic [7:0] OP_GET_SIGNAL = 8'h0e;
  localparam logic [7:0] OP_SLEEP_IN = 8'h10;
  localparam logic [7:0] OP_SLEEP_OUT = 8'h11;
  localparam logic [7:0] OP_PARTIAL = 8'h12;
  localparam logic [7:0] OP_NORMAL = 8'h13;
  localparam logic [7:0] OP_INVERT_OFF = 8'h20;
  localparam logic [7:0] OP_INVERT_ON = 8'h21;
  localparam logic [7:0] OP_DISPLAY_OFF = 8'h28;
  localparam logic [7:0] OP_DISPLAY_ON = 8'h29;
  localparam logic [7:0] OP_WRITE_START = 8'h2c;
  localparam logic [7:0] OP_READ_START = 8'h2e;
  localparam logic [7:0] OP_TEAR_OFF = 8'h34;
  localparam logic [7:0] OP_TEAR_ON = 8'h35;
  localparam logic [7:0] OP_SET_ADDR = 8'h36;
  localparam logic [7:0] OP_IDLE_OFF = 8'h38;
  localparam logic [7:0] OP_IDLE_ON = 8'h39;
  localparam logic [7:0] OP_SET_PIXFMT = 8'h3a;
  localparam logic [7:0] OP_WRITE_CONT = 8'h3c;
  localparam logic [7:0] OP_READ_CONT = 8'h3e;
  localparam logic [7:0] OP_TEAR_LINE = 8'h44;
  localparam logic [7:0] OP_SET_PIN_CONF = 8'hb8;
  localparam logic [7:0] OP_SET_PIN_VALUE = 8'hba;
  localparam logic [7:0] OP_GET_PIN_STATUS = 8'hbb;
  localparam logic [7:0] OP_SET_ROP_BASE = 8'hc8;
  localparam logic [7:0] OP_SET_PLL = 8'he0;

  // ==========================================================================
  // Field layouts and reset values
  localparam int PWR_IDLE_BIT = 6;
  localparam int PWR_PARTIAL_BIT = 5;
  localparam int PWR_SLEEP_BIT = 4;
  localparam int PWR_NORMAL_BIT = 3;
  localparam int PWR_DISPLAY_BIT = 2;
  localparam int PIXFMT_LSB = 4;
  localparam int SIGNAL_TEAR_BIT = 7;
  localparam logic [7:0] ADDR_MODE_MASK = 8'hfc;
  localparam logic [7:0] ADDR_MODE_RESET = 8'h00;
  localparam logic [2:0] PIXFMT_RESET = 3'h0;
  localparam logic [2:0] PIXFMT_RSVD_LO = 3'h0;
  localparam logic [2:0] PIXFMT_3BPP = 3'h1;
  localparam logic [2:0] PIXFMT_8BPP = 3'h2;
  localparam logic [2:0] PIXFMT_12BPP = 3'h3;
  localparam logic [2:0] PIXFMT_RSVD_HI = 3'h4;
  localparam logic [2:0] PIXFMT_16BPP = 3'h5;
  localparam logic [2:0] PIXFMT_18BPP = 3'h6;
  localparam logic [2:0] PIXFMT_24BPP = 3'h7;
  localparam logic [8:0] PIN_CONF_RESET = 9'h100;
  localparam int PIN_POWER_BIT = 8;
  localparam int PIN_COUNT = 4;

  // ==========================================================================
  // Wishbone register map (byte addresses)
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_PIN_CONF = 4'h4;
  localparam logic [3:0] REG_ROP = 4'h8;
  localparam logic [3:0] REG_TEAR = 4'hc;

  typedef enum logic [1:0] {DHC_MEM_IDLE, DHC_MEM_WRITE, DHC_MEM_READ} dhc_mem_t;

endpackage

// ===== dhc_decoder.sv
// Display host command decoder: takes command and parameter bytes from the
// host port, keeps the configuration state and answers the status reads.
// Assumes host strobes come from same-clock logic; pins are synchronised.
//
// Operation
// [RQ1] Select low is opcode, high is parameter/pixel.
// [RQ2] Opcode 00 changes nothing, ends memory transfers.
// [RQ3] Opcode 01 restores configuration defaults only.
// [RQ4] Host waits 5 ms after soft reset.
// [RQ5] Host waits 120 ms before exit-sleep.
// [RQ6] Enter-sleep: panel off, pin zero low.
// [RQ7] Exit-sleep: panel on, pin zero high.
// [RQ8] Power-mode byte layout, normal bit resets one.
// [RQ9] Power-mode sleep bit reads inverted.
// [RQ10] Address-mode read reports memory ordering bits.
// [RQ11] Address-mode read reports refresh ordering bits.
// [RQ12] Pixel-format read: field 6:4, low codes.
// [RQ13] Pixel-format codes 101-111 are 16/18/24 bpp.
// [RQ14] Tear-on enables sync at front porch; off suppresses.
// [RQ15] Tear-scanline issues sync at host scanline.
// [RQ16] Write start from window start; continue resumes.
// [RQ17] Read start from window start; continue resumes.
// [RQ18] Partial restricts display; normal restores all.
// [RQ19] Invert on/off, frame memory untouched.
// [RQ20] Display off blanks, display on shows.
// [RQ21] Idle reduces colour depth, exit restores.
// [RQ22] Raster-op set ignored on plain general pins.
// [RQ23] Pin status: live level for inputs.
// [RQ24] PLL start enables PLL; reference until selected.
// [RQ25] Reserved or unknown opcodes change nothing.
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dhc_decoder
  import dhc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic hostDc,
  input wire logic [7:0] hostData,
  output logic [7:0] hostRdData,
  output logic hostRdValid,
  input wire logic [7:0] fbRdData,
  output logic memWrEn,
  output logic memWrFirst,
  output logic [7:0] memWrData,
  output logic memRdEn,
  output logic memRdFirst,
  input wire logic vfpStart,
  input wire logic lineStart,
  input wire logic [15:0] lineNum,
  output logic tearOut,
  output logic panelOn,
  output logic partialOut,
  output logic invertOut,
  output logic idleOut,
  output logic [7:0] addrModeOut,
  output logic pixFmtValid,
  output logic pllEnable,
  output logic pllSelect,
  input wire logic [3:0] pinIn,
  input wire logic [3:0] lcdGen,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ==========================================================================
  // Command stream decode
  logic [7:0] opcode;
  logic [7:0] paramIdx;
  dhc_mem_t memMode;
  logic memFirst;
  logic cmdWr;
  logic parWr;
  logic cfgClr;
  logic wbWr;

  // Select low marks an opcode, select high a parameter or pixel byte.
  assign cmdWr = ce && hostWr && !hostDc; // [RQ1]
  assign parWr = ce && hostWr && hostDc; // [RQ1]
  assign cfgClr = cmdWr && (hostData == OP_SOFT_RESET); // [RQ3]
  assign wbWr = ce && wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o; // Lands at the ack edge.

  // Latch the current opcode and count its parameter bytes.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      opcode <= OP_NOP;
      paramIdx <= 8'h00;
    end else if (cmdWr) begin
      opcode <= hostData;
      paramIdx <= 8'h00;
    end else if (parWr && paramIdx != 8'hff) begin
      paramIdx <= paramIdx + 8'h01;
    end
  end

  // Memory transfer state; any new opcode, nop included, ends a transfer.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      memMode <= DHC_MEM_IDLE;
      memFirst <= 1'b0;
    end else if (cmdWr) begin
      memFirst <= (hostData == OP_WRITE_START) || (hostData == OP_READ_START);
      case (hostData)
        OP_WRITE_START, OP_WRITE_CONT: memMode <= DHC_MEM_WRITE; // [RQ16]
        OP_READ_START, OP_READ_CONT: memMode <= DHC_MEM_READ; // [RQ17]
        default: memMode <= DHC_MEM_IDLE; // [RQ2]
      endcase
    end else if ((parWr && memMode == DHC_MEM_WRITE) ||
                 (ce && hostRd && memMode == DHC_MEM_READ)) begin
      memFirst <= 1'b0;
    end
  end

  // Pixel and read strobes to the frame-buffer sequencer; first marks a restart.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      memWrEn <= 1'b0;
      memWrFirst <= 1'b0;
      memWrData <= 8'h00;
      memRdEn <= 1'b0;
      memRdFirst <= 1'b0;
    end else if (ce) begin
      memWrEn <= parWr && memMode == DHC_MEM_WRITE; // [RQ16]
      memWrFirst <= memFirst;
      memRdEn <= hostRd && memMode == DHC_MEM_READ; // [RQ17]
      memRdFirst <= memFirst;
      if (parWr) begin
        memWrData <= hostData;
      end
    end
  end

  // ==========================================================================
  // Configuration state; soft reset returns all of it to defaults.
  logic sleepOn;
  logic displayOn;
  logic partialOn;
  logic invertOn;
  logic idleOn;
  logic tearOn;
  logic tearLineOn;
  logic [15:0] tearLine;
  logic [7:0] addrMode;
  logic [2:0] pixFmt;
  logic pllEn;
  logic pllSel;

  // Mode switches. Unlisted opcodes fall to the default and touch nothing.
  always_ff @(posedge clk) begin
    if (!rst_b || cfgClr) begin // [RQ3]
      sleepOn <= 1'b1;
      displayOn <= 1'b0;
      partialOn <= 1'b0;
      invertOn <= 1'b0;
      idleOn <= 1'b0;
      pllEn <= 1'b0;
      pllSel <= 1'b0;
    end else if (cmdWr) begin
      case (hostData)
        OP_SLEEP_IN: sleepOn <= 1'b1; // [RQ6]
        OP_SLEEP_OUT: sleepOn <= 1'b0; // [RQ7]
        OP_PARTIAL: partialOn <= 1'b1; // [RQ18]
        OP_NORMAL: partialOn <= 1'b0; // [RQ18]
        OP_INVERT_ON: invertOn <= 1'b1; // [RQ19]
        OP_INVERT_OFF: invertOn <= 1'b0; // [RQ19]
        OP_DISPLAY_ON: displayOn <= 1'b1; // [RQ20]
        OP_DISPLAY_OFF: displayOn <= 1'b0; // [RQ20]
        OP_IDLE_ON: idleOn <= 1'b1; // [RQ21]
        OP_IDLE_OFF: idleOn <= 1'b0; // [RQ21]
        default: sleepOn <= sleepOn; // [RQ2] [RQ25]
      endcase
    end else if (parWr && opcode == OP_SET_PLL && paramIdx == 8'h00) begin
      pllEn <= hostData[0]; // [RQ24]
      pllSel <= hostData[1] && hostData[0];
    end
  end

  // Parameterised settings: address mode, pixel format and tear control.
  always_ff @(posedge clk) begin
    if (!rst_b || cfgClr) begin
      tearOn <= 1'b0;
      tearLineOn <= 1'b0;
      tearLine <= 16'h0000;
      addrMode <= ADDR_MODE_RESET;
      pixFmt <= PIXFMT_RESET;
    end else if (cmdWr && hostData == OP_TEAR_OFF) begin
      tearOn <= 1'b0; // [RQ14]
      tearLineOn <= 1'b0;
    end else if (cmdWr && hostData == OP_TEAR_ON) begin
      tearOn <= 1'b1; // [RQ14]
      tearLineOn <= 1'b0;
    end else if (parWr) begin
      if (opcode == OP_SET_ADDR && paramIdx == 8'h00) begin
        addrMode <= hostData & ADDR_MODE_MASK; // [RQ10] [RQ11]
      end
      if (opcode == OP_SET_PIXFMT && paramIdx == 8'h00) begin
        pixFmt <= hostData[PIXFMT_LSB +: 3]; // [RQ12]
      end
      if (opcode == OP_TEAR_LINE && paramIdx == 8'h00) begin
        tearLine[15:8] <= hostData;
      end
      if (opcode == OP_TEAR_LINE && paramIdx == 8'h01) begin
        tearLine[7:0] <= hostData; // [RQ15]
        tearOn <= 1'b1;
        tearLineOn <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // General pins: configuration, values and raster-op settings.
  logic [8:0] pinConf;
  logic [3:0] pinVal;
  logic [7:0] ropCfg [PIN_COUNT];
  logic [3:0] pinSync1;
  logic [3:0] pinSync2;
  logic pin0Power;

  // Pin zero follows sleep only when it is neither plain general nor LCD.
  assign pin0Power = pinConf[PIN_POWER_BIT] && !pinConf[4];

  // Bits 3:0 drive enable per pin, 7:4 LCD signal select, 8 power control.
  always_ff @(posedge clk) begin
    if (!rst_b || cfgClr) begin
      pinConf <= PIN_CONF_RESET;
    end else if (wbWr && wb_adr_i == REG_PIN_CONF && wb_sel_i[0]) begin
      pinConf <= {wb_dat_i[8] & wb_sel_i[1], wb_dat_i[7:0]};
    end else if (parWr && opcode == OP_SET_PIN_CONF && paramIdx == 8'h00) begin
      pinConf[7:0] <= hostData;
    end else if (parWr && opcode == OP_SET_PIN_CONF && paramIdx == 8'h01) begin
      pinConf[PIN_POWER_BIT] <= hostData[0];
    end
  end

  // Programmed pin values; sleep commands steer pin zero in power mode.
  always_ff @(posedge clk) begin
    if (!rst_b || cfgClr) begin
      pinVal <= 4'h0;
    end else if (cmdWr && hostData == OP_SLEEP_IN && pin0Power) begin
      pinVal[0] <= 1'b0; // [RQ6]
    end else if (cmdWr && hostData == OP_SLEEP_OUT && pin0Power) begin
      pinVal[0] <= 1'b1; // [RQ7]
    end else if (parWr && opcode == OP_SET_PIN_VALUE && paramIdx == 8'h00) begin
      pinVal <= hostData[3:0];
    end
  end

  // Two-stage synchroniser for the pin levels; only stage two is read.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pinSync1 <= 4'h0;
      pinSync2 <= 4'h0;
    end else if (ce) begin
      pinSync1 <= pinIn;
      pinSync2 <= pinSync1;
    end
  end

  // Per-pin raster-op storage and pin drivers, one slice per pin.
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    always_ff @(posedge clk) begin
      if (!rst_b || cfgClr) begin
        ropCfg[p] <= 8'h00;
      end else if (parWr && paramIdx == 8'h00 &&
                   opcode == OP_SET_ROP_BASE + 8'(2 * p) && pinConf[4 + p]) begin
        ropCfg[p] <= hostData; // [RQ22]
      end
    end
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        pinOut[p] <= 1'b0;
        pinOe_b[p] <= 1'b1;
      end else if (ce) begin
        pinOut[p] <= pinConf[4 + p] ? lcdGen[p] : pinVal[p];
        pinOe_b[p] <= !(pinConf[4 + p] || pinConf[p]);
      end
    end
  end

  // ==========================================================================
  // Host read answers and status outputs.
  logic [7:0] powerByte;
  logic [7:0] statusByte;

  assign powerByte = (8'(idleOn) << PWR_IDLE_BIT) | (8'(partialOn) << PWR_PARTIAL_BIT) |
                     (8'(!sleepOn) << PWR_SLEEP_BIT) | // [RQ9]
                     (8'(!partialOn) << PWR_NORMAL_BIT) | // [RQ8]
                     (8'(displayOn) << PWR_DISPLAY_BIT);

  // Pins with drive enable bit clear show their live level, pins with it set their programmed value.
  always_comb begin
    case (opcode)
      OP_GET_POWER: statusByte = powerByte; // [RQ8]
      OP_GET_ADDR: statusByte = addrMode; // [RQ10] [RQ11]
      OP_GET_PIXFMT: statusByte = 8'(pixFmt) << PIXFMT_LSB; // [RQ12]
      OP_GET_SIGNAL: statusByte = 8'(tearOn) << SIGNAL_TEAR_BIT;
      OP_GET_PIN_STATUS: statusByte = {4'h0, (pinSync2 & ~pinConf[3:0]) |
                                       (pinVal & pinConf[3:0])}; // [RQ23]
      default: statusByte = 8'h00;
    endcase
  end

  // Read data is answered one cycle after the read strobe.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hostRdData <= 8'h00;
      hostRdValid <= 1'b0;
    end else if (ce) begin
      hostRdValid <= hostRd;
      if (hostRd) begin
        hostRdData <= (memMode == DHC_MEM_READ) ? fbRdData : statusByte; // [RQ17]
      end
    end
  end

  // Panel-facing state and the tear indication.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      panelOn <= 1'b0;
      partialOut <= 1'b0;
      invertOut <= 1'b0;
      idleOut <= 1'b0;
      addrModeOut <= ADDR_MODE_RESET;
      pixFmtValid <= 1'b0;
      pllEnable <= 1'b0;
      pllSelect <= 1'b0;
      tearOut <= 1'b0;
    end else if (ce) begin
      panelOn <= displayOn && !sleepOn; // [RQ20] [RQ6] [RQ7]
      partialOut <= partialOn; // [RQ18]
      invertOut <= invertOn; // [RQ19]
      idleOut <= idleOn; // [RQ21]
      addrModeOut <= addrMode;
      pixFmtValid <= (pixFmt != PIXFMT_RSVD_LO) && (pixFmt != PIXFMT_RSVD_HI); // [RQ13]
      pllEnable <= pllEn; // [RQ24]
      pllSelect <= pllSel;
      tearOut <= tearOn && (tearLineOn ? (lineStart && lineNum == tearLine)
                                       : vfpStart); // [RQ14] [RQ15]
    end
  end

  // ==========================================================================
  // Wishbone slave: one wait state, unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      case (wb_adr_i)
        REG_STATUS: wb_dat_o <= {10'h000, pllSel, pllEn, tearOn, pixFmt, addrMode, powerByte};
        REG_PIN_CONF: wb_dat_o <= {23'h000000, pinConf};
        REG_ROP: wb_dat_o <= {ropCfg[3], ropCfg[2], ropCfg[1], ropCfg[0]};
        REG_TEAR: wb_dat_o <= {15'h0000, tearLineOn, tearLine};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Checks on the decoded behaviour.
  nop_holds_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    cmdWr && hostData == OP_NOP |=> $stable(sleepOn) && $stable(displayOn) &&
    $stable(addrMode) && memMode == DHC_MEM_IDLE) else $error("nop changed state"); // [RQ2]
  soft_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
    cfgClr |=> addrMode == ADDR_MODE_RESET && !tearOn && sleepOn && pixFmt == PIXFMT_RESET)
    else $error("soft reset left config"); // [RQ3]
  sleep_pin_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmdWr && hostData == OP_SLEEP_IN && pin0Power && !pinConf[0] |=> !pinVal[0])
    else $error("sleep did not lower pin zero"); // [RQ6]
  wake_pin_a: assert property (@(posedge clk) disable iff (!rst_b)
    cmdWr && hostData == OP_SLEEP_OUT && !pin0Power |=> $stable(pinVal[0]))
    else $error("wake touched unpowered pin"); // [RQ7]
  power_read_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    hostRd && opcode == OP_GET_POWER && memMode == DHC_MEM_IDLE |=>
    hostRdValid && hostRdData[PWR_SLEEP_BIT] == !$past(sleepOn) && hostRdData[1:0] == 2'b00)
    else $error("power byte wrong"); // [RQ8] [RQ9]
  tear_off_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    !tearOn |=> !tearOut) else $error("tear while disabled"); // [RQ14]
  write_stream_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    cmdWr && hostData == OP_WRITE_START ##1 !hostWr ##1 parWr |=> memWrEn && memWrFirst)
    else $error("write start lost"); // [RQ16]
  rop_guard_a: assert property (@(posedge clk) disable iff (!rst_b)
    !pinConf[4] && !cfgClr |=> $stable(ropCfg[0]))
    else $error("rop changed on general pin"); // [RQ22]
  panel_on_a: assert property (@(posedge clk) disable iff (!rst_b || !ce)
    displayOn && !sleepOn |=> panelOn) else $error("panel not shown"); // [RQ20]

endmodule

`default_nettype wire

// ===== dhc_host_model.sv
// Host processor model for the parallel command port of the decoder.
// Assumes it shares the decoder clock; the bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none

module dhc_host_model #(
  parameter int SRST_WAIT = 50,
  parameter int WAKE_WAIT = 120
) (
  input wire logic clk,
  output logic hostWr,
  output logic hostRd,
  output logic hostDc,
  output logic [7:0] hostData,
  input wire logic [7:0] hostRdData,
  input wire logic hostRdValid
);
  // The host waits are scaled down, since the device does not time them.
  longint cyc = 0;
  longint rstAt = -100000;

  initial begin
    hostWr = 1'b0;
    hostRd = 1'b0;
    hostDc = 1'b1;
    hostData = 8'h00;
  end

  // Free cycle count used to space the wake command after a soft reset.
  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  // ==========================================================================
  // Byte transfers
  // Select low marks an opcode, high a parameter or pixel.
  task automatic put(input logic dc, input logic [7:0] b);
    @(posedge clk);
    hostWr <= 1'b1;
    hostDc <= dc;
    hostData <= b;
    @(posedge clk);
    hostWr <= 1'b0;
    hostData <= ~b; // A released bus must not keep showing the last byte.
  endtask

  task automatic cmd(input logic [7:0] op);
    if (op == 8'h11) begin
      while (cyc - rstAt < WAKE_WAIT) @(posedge clk);
    end
    put(1'b0, op);
    if (op == 8'h01) begin
      rstAt = cyc;
      repeat (SRST_WAIT) @(posedge clk);
    end
  endtask

  // The answer is looked for over a few cycles only, so a dead port ends.
  task automatic rd(output logic [7:0] b, output logic ok);
    int i;
    @(posedge clk);
    hostRd <= 1'b1;
    @(posedge clk);
    hostRd <= 1'b0;
    ok = 1'b0;
    b = 8'h00;
    for (i = 0; i < 4 && ok == 1'b0; i++) begin
      @(posedge clk);
      if (hostRdValid === 1'b1) begin
        ok = 1'b1;
        b = hostRdData;
      end
    end
  endtask
endmodule

`default_nettype wire

// ===== display_host_command_decoder_test.sv
// Self-checking bench for the display host command decoder.
// Assumes one 100 MHz clock for decoder, host model and bus.
`timescale 1ns/1ps
`default_nettype none

module display_host_command_decoder_test
  import dhc_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic hostWr, hostRd, hostDc, hostRdValid, memWrEn, memWrFirst, memRdEn, memRdFirst;
  logic [7:0] hostData, hostRdData, memWrData, addrModeOut, fbRdData = 8'h5a;
  logic vfpStart = 1'b0, lineStart = 1'b0, tearOut, panelOn, partialOut, invertOut;
  logic idleOut, pixFmtValid, pllEnable, pllSelect, wb_ack_o;
  logic [15:0] lineNum = 16'h0;
  logic [3:0] pinIn = 4'ha, lcdGen = 4'h0, pinOut, pinOe_b, wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  int n_mismatch = 0, checks_done = 0;
  int nWr = 0, nWrFirst = 0, nRd = 0, nRdFirst = 0, nTear = 0;
  logic [7:0] lastWr;

  dhc_decoder dut (.clk(clk), .rst_b(rst_b), .ce(ce), .hostWr(hostWr), .hostRd(hostRd),
    .hostDc(hostDc), .hostData(hostData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .fbRdData(fbRdData), .memWrEn(memWrEn),
    .memWrFirst(memWrFirst), .memWrData(memWrData), .memRdEn(memRdEn),
    .memRdFirst(memRdFirst), .vfpStart(vfpStart), .lineStart(lineStart), .lineNum(lineNum),
    .tearOut(tearOut), .panelOn(panelOn), .partialOut(partialOut), .invertOut(invertOut),
    .idleOut(idleOut), .addrModeOut(addrModeOut), .pixFmtValid(pixFmtValid),
    .pllEnable(pllEnable), .pllSelect(pllSelect), .pinIn(pinIn), .lcdGen(lcdGen),
    .pinOut(pinOut), .pinOe_b(pinOe_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  dhc_host_model #(.SRST_WAIT(50), .WAKE_WAIT(120)) host (.clk(clk), .hostWr(hostWr),
    .hostRd(hostRd), .hostDc(hostDc), .hostData(hostData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid));

  initial begin
    forever #5 clk = ~clk;
  end

  // Pulses are counted here, so a pulse of one cycle is never missed.
  always @(posedge clk) begin
    if (memWrEn === 1'b1) begin
      nWr++;
      nWrFirst += memWrFirst;
      lastWr = memWrData;
    end
    if (memRdEn === 1'b1) begin
      nRd++;
      nRdFirst += memRdFirst;
    end
    if (tearOut === 1'b1) nTear++;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (i == 8) begin
      n_mismatch++;
      final_report();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic get(input logic [7:0] op, input logic [7:0] exp, input string what);
    logic [7:0] b;
    logic ok;
    host.cmd(op);
    host.rd(b, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
    check(what, b, exp);
  endtask

  task automatic cp(input logic [7:0] op, input logic [7:0] p);
    host.cmd(op);
    host.put(1'b1, p);
  endtask

  task automatic pulse(input logic isLine, input logic [15:0] n);
    @(posedge clk);
    vfpStart <= ~isLine;
    lineStart <= isLine;
    lineNum <= n;
    @(posedge clk);
    vfpStart <= 1'b0;
    lineStart <= 1'b0;
    settle();
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] q;
    static logic [7:0] mOp [8] = '{8'h29, 8'h12, 8'h13, 8'h39, 8'h38, 8'h21, 8'h20, 8'h28};
    static logic [7:0] mPw [8] = '{8'h1c, 8'h34, 8'h1c, 8'h5c, 8'h1c, 8'h1c, 8'h1c, 8'h18};
    static logic [3:0] mLv [8] = '{4'h1, 4'h9, 4'h1, 4'h5, 4'h1, 4'h3, 4'h1, 4'h0};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    get(OP_GET_POWER, 8'h08, "power");
    get(OP_GET_ADDR, 8'h00, "addr mode");
    get(OP_GET_PIXFMT, 8'h00, "pixel format");
    get(OP_GET_PIN_STATUS, 8'h0a, "pin status");
    wb(1'b0, REG_STATUS, 32'h0, q);
    check("status", q, 32'h8);
    host.cmd(OP_SLEEP_OUT);
    settle();
    check("pin zero wake", pinOut[0], 1'b1);
    get(OP_GET_POWER, 8'h18, "power awake");
    for (int i = 0; i < 8; i++) begin
      host.cmd(mOp[i]);
      settle();
      check("levels", {partialOut, idleOut, invertOut, panelOn}, mLv[i]);
      get(OP_GET_POWER, mPw[i], "power mode");
    end
    cp(8'h0f, 8'h3c);
    cp(8'ha8, 8'h3c);
    cp(8'hff, 8'h3c);
    get(OP_GET_POWER, 8'h18, "power unknown");
    cp(OP_SET_ADDR, 8'hff);
    get(OP_GET_ADDR, 8'hfc, "addr mode set");
    check("addr out", addrModeOut, 8'hfc);
    for (int c = 0; c < 8; c++) begin
      cp(OP_SET_PIXFMT, {1'b0, c[2:0], 4'h0});
      get(OP_GET_PIXFMT, {1'b0, c[2:0], 4'h0}, "pixel format set");
      check("format valid", pixFmtValid, c != 0 && c != 4);
    end
    host.cmd(OP_WRITE_START);
    host.put(1'b1, 8'ha1);
    host.put(1'b1, 8'ha2);
    host.cmd(OP_NOP);
    host.put(1'b1, 8'h77);
    settle();
    check("write count", nWr, 2);
    check("write data", lastWr, 8'ha2);
    host.cmd(OP_WRITE_CONT);
    host.put(1'b1, 8'hb3);
    settle();
    check("write resume", {nWr[7:0], nWrFirst[7:0], lastWr}, 24'h0301b3);
    get(OP_READ_START, 8'h5a, "read data");
    get(OP_READ_CONT, 8'h5a, "read resume");
    get(OP_NOP, 8'h00, "read after nop");
    check("read counts", {nRd[7:0], nRdFirst[7:0]}, 16'h0201);
    host.cmd(OP_TEAR_ON);
    pulse(1'b0, 16'h0);
    check("tear on", nTear, 1);
    wb(1'b0, REG_STATUS, 32'h0, q);
    check("status tear", q[19], 1'b1);
    host.cmd(OP_TEAR_OFF);
    pulse(1'b0, 16'h0);
    check("tear off", nTear, 1);
    cp(OP_TEAR_LINE, 8'h00);
    host.put(1'b1, 8'h07);
    wb(1'b0, REG_TEAR, 32'h0, q);
    check("tear line", q, 32'h10007);
    pulse(1'b1, 16'h6);
    pulse(1'b1, 16'h7);
    check("tear at line", nTear, 2);
    cp(OP_SET_PLL, 8'h01);
    settle();
    check("pll start", {pllSelect, pllEnable}, 2'b01);
    cp(OP_SET_PLL, 8'h03);
    settle();
    check("pll select", {pllSelect, pllEnable}, 2'b11);
    wb(1'b1, REG_PIN_CONF, 32'h100, q);
    cp(OP_SET_ROP_BASE, 8'h55);
    wb(1'b0, REG_ROP, 32'h0, q);
    check("rop general", q, 32'h0);
    wb(1'b1, REG_PIN_CONF, 32'h110, q);
    cp(OP_SET_ROP_BASE, 8'h55);
    wb(1'b0, REG_ROP, 32'h0, q);
    check("rop lcd", q[7:0], 8'h55);
    wb(1'b1, REG_PIN_CONF, 32'h100, q);
    host.cmd(OP_SLEEP_IN);
    settle();
    check("pin zero sleep", {pinOut[0], panelOn}, 2'b00);
    get(OP_GET_POWER, 8'h08, "power asleep");
    wb(1'b1, REG_PIN_CONF, 32'h0, q);
    wb(1'b0, REG_PIN_CONF, 32'h0, q);
    check("pin conf", q, 32'h0);
    host.cmd(OP_SLEEP_OUT);
    settle();
    check("pin zero kept", pinOut[0], 1'b0);
    wb(1'b1, 4'h2, 32'hffffffff, q);
    wb(1'b0, 4'h2, 32'h0, q);
    check("unmapped", q, 32'h0);
    wb(1'b1, REG_PIN_CONF, 32'h3, q);
    cp(OP_SET_PIN_VALUE, 8'h05);
    get(OP_GET_PIN_STATUS, 8'h09, "pin status mixed");
    check("pin drive", {pinOe_b, pinOut}, 8'hc5);
    host.cmd(OP_SOFT_RESET);
    get(OP_GET_POWER, 8'h08, "power soft reset");
    get(OP_GET_ADDR, 8'h00, "addr soft reset");
    wb(1'b0, REG_PIN_CONF, 32'h0, q);
    check("pin conf soft reset", q, 32'h100);
    final_report();
  end
endmodule

`default_nettype wire
